// file: src/port_cfg_regs.vh
// Register offsets, field layout, reset values and timing counts for the pin mode block
`ifndef PORT_CFG_REGS_VH
`define PORT_CFG_REGS_VH

// Byte offsets of the mode-select registers on the register bus
`define PORT0_MODE_SELECT_LOW_OFS  8'h00
`define PORT0_MODE_SELECT_HIGH_OFS 8'h04
`define PORT1_MODE_SELECT_LOW_OFS  8'h08
`define PORT1_MODE_SELECT_HIGH_OFS 8'h0C
`define PORT2_MODE_SELECT_LOW_OFS  8'h10
`define PORT2_MODE_SELECT_HIGH_OFS 8'h14
`define PORT3_MODE_SELECT_LOW_OFS  8'h18
`define PORT3_MODE_SELECT_HIGH_OFS 8'h1C
// Output latch registers, one per port
`define PORT0_LATCH_OFS            8'h20
`define PORT1_LATCH_OFS            8'h24
`define PORT2_LATCH_OFS            8'h28
`define PORT3_LATCH_OFS            8'h2C
// Sensed pin levels, read only, one per port
`define PORT0_LEVEL_OFS            8'h30
`define PORT1_LEVEL_OFS            8'h34
`define PORT2_LEVEL_OFS            8'h38
`define PORT3_LEVEL_OFS            8'h3C
// Power-down control, bit 0
`define POWER_DOWN_OFS             8'h40
`define POWER_DOWN_BIT             0

// Reset values
`define MODE_SELECT_RESET          8'h00
`define LATCH_RESET                8'hFF
`define POWER_DOWN_RESET           1'b0

// Port 0 implements only the low four mode bits
`define PORT0_MODE_MASK            8'h0F

// Mode codes {first bit, second bit}
`define MODE_QUASI                 2'b00
`define MODE_PUSH_PULL             2'b01
`define MODE_INPUT_ONLY            2'b10
`define MODE_OPEN_DRAIN            2'b11

// Wake pins: port 3 bits 2 and 3, flat pin index
`define WAKE_PIN_A_IDX             22
`define WAKE_PIN_B_IDX             23

// Strong pull-up pulse length in CPU clocks
`define STRONG_PULSE_CLOCKS        2'h2

// AXI response codes
`define AXI_RESP_OKAY              2'b00
`define AXI_RESP_SLVERR            2'b10

`endif

// file: src/pin_driver.v
// One pin's mode decode, pull-up sequencing and input gating
`timescale 1ns/100ps
`include "port_cfg_regs.vh"

module pin_driver #(
  parameter WAKE_CAPABLE = 0
) (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire [1:0] mode_i,
  input  wire       latch_i,
  input  wire       level_i,
  input  wire       power_down_i,
  output reg        pull_down_o,
  output reg        very_weak_up_o,
  output reg        weak_up_o,
  output reg        strong_up_o,
  output reg        input_enable_o,
  output reg        level_o
);

  reg       latch_prev;
  reg [1:0] strong_count;
  wire      quasi      = (mode_i == `MODE_QUASI);
  wire      rise_start = quasi && latch_i && !latch_prev;

  // Strong pulse counter; restarts on each 0 to 1 latch change in quasi mode
  always @(posedge clock_i) begin
    if (reset_i) begin
      latch_prev   <= 1'b1;
      strong_count <= 2'h0;
    end else begin
      latch_prev <= latch_i;
      if (rise_start)
        strong_count <= `STRONG_PULSE_CLOCKS;
      else if (strong_count != 2'h0)
        strong_count <= strong_count - 2'h1;
    end
  end

  // Drivers are registered so the pads see glitch-free enables
  always @(posedge clock_i) begin
    if (reset_i) begin
      pull_down_o    <= 1'b0;
      very_weak_up_o <= 1'b1;
      weak_up_o      <= 1'b0;
      strong_up_o    <= 1'b0;
      input_enable_o <= 1'b1;
      level_o        <= 1'b0;
    end else begin
      // Input-only drives nothing; others share one pull-down
      pull_down_o    <= (mode_i != `MODE_INPUT_ONLY) && !latch_i;
      very_weak_up_o <= quasi && latch_i;
      weak_up_o      <= quasi && latch_i && level_i;
      case (mode_i)
        `MODE_QUASI:      strong_up_o <= rise_start || (strong_count == `STRONG_PULSE_CLOCKS);
        `MODE_PUSH_PULL:  strong_up_o <= latch_i;
        `MODE_INPUT_ONLY: strong_up_o <= 1'b0;
        `MODE_OPEN_DRAIN: strong_up_o <= 1'b0;
        default:          strong_up_o <= 1'b0;
      endcase
      // Only wake pins keep their Schmitt input in power-down
      input_enable_o <= !power_down_i || (WAKE_CAPABLE != 0);
      level_o        <= level_i && (!power_down_i || (WAKE_CAPABLE != 0));
    end
  end

endmodule // pin_driver

// file: src/port_pin_mode_config.v
// Register file and pin array for the four general-purpose ports
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "port_cfg_regs.vh"

// Behaviour
// - 27 pins, each with own mode pair
// - Decode 00 quasi, 01 push, 10 input, 11 drain
// - All mode bits reset to zero
// - Power-down gates inputs except two wake pins
// - Quasi: latch zero drives strong low
// - Quasi: weak high, overridable, input/output
// - Quasi: very weak pull-up while latch one
// - Quasi: weak pull-up needs latch and pin high
// - Quasi: strong pull-up two clocks on rise
// - Port 0 implements mode bits 3..0 only
// - Open-drain: no pull-ups, low on zero
// - Input-only: no drive, no pull-up
// - Push-pull: strong high while latch one
module port_pin_mode_config #(
  parameter NUM_PINS = 27
) (
  input  wire                CLOCK_I,
  input  wire                SYS_RST_I,
  input  wire [7:0]          S_AXI_AWADDR_I,
  input  wire                S_AXI_AWVALID_I,
  output reg                 S_AXI_AWREADY_O,
  input  wire [31:0]         S_AXI_WDATA_I,
  input  wire [3:0]          S_AXI_WSTRB_I,
  input  wire                S_AXI_WVALID_I,
  output reg                 S_AXI_WREADY_O,
  output reg  [1:0]          S_AXI_BRESP_O,
  output reg                 S_AXI_BVALID_O,
  input  wire                S_AXI_BREADY_I,
  input  wire [7:0]          S_AXI_ARADDR_I,
  input  wire                S_AXI_ARVALID_I,
  output reg                 S_AXI_ARREADY_O,
  output reg  [31:0]         S_AXI_RDATA_O,
  output reg  [1:0]          S_AXI_RRESP_O,
  output reg                 S_AXI_RVALID_O,
  input  wire                S_AXI_RREADY_I,
  input  wire [NUM_PINS-1:0] PIN_LEVEL_I,
  output wire [NUM_PINS-1:0] PULL_DOWN_O,
  output wire [NUM_PINS-1:0] VERY_WEAK_UP_O,
  output wire [NUM_PINS-1:0] WEAK_UP_O,
  output wire [NUM_PINS-1:0] STRONG_UP_O,
  output wire [NUM_PINS-1:0] INPUT_ENABLE_O,
  output reg                 POWER_DOWN_O
);

  // Pins: port 0 bits 3..0, then ports 1..3 (but port 3 full width
  // is trimmed to keep 27 pins: ports 1, 2 full, port 3 bits 6..0)
  reg  [7:0]          mode_low [0:3];
  reg  [7:0]          mode_high[0:3];
  reg  [7:0]          latch    [0:3];
  reg  [NUM_PINS-1:0] level_meta;
  reg  [NUM_PINS-1:0] level_sync;
  wire [NUM_PINS-1:0] level_gated;
  wire [31:0]         flat_low;
  wire [31:0]         flat_high;
  wire [31:0]         flat_latch;
  wire [31:0]         flat_level;

  // AXI write side state
  reg                 aw_held;
  reg                 w_held;
  reg  [7:0]          aw_addr;
  reg  [7:0]          w_data;
  reg                 w_lane0;
  reg                 next_wr_ok;
  reg                 next_rd_ok;
  reg  [31:0]         next_rdata;

  integer i;

  // Pad levels come from outside; two flops before any use
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      level_meta <= {NUM_PINS{1'b0}};
      level_sync <= {NUM_PINS{1'b0}};
    end else begin
      level_meta <= PIN_LEVEL_I;
      level_sync <= level_meta;
    end
  end

  // Flatten per-port bytes into pin order
  assign flat_low   = {5'h00, mode_low[3][6:0], mode_low[2], mode_low[1], mode_low[0][3:0]};
  assign flat_high  = {5'h00, mode_high[3][6:0], mode_high[2], mode_high[1],
                       mode_high[0][3:0]};
  assign flat_latch = {5'h00, latch[3][6:0], latch[2], latch[1], latch[0][3:0]};
  assign flat_level = {{(32-NUM_PINS){1'b0}}, level_gated};

  // One driver per pin, mode pair taken from both registers
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : pin_gen
      pin_driver #(
        .WAKE_CAPABLE ((g == `WAKE_PIN_A_IDX) || (g == `WAKE_PIN_B_IDX))
      ) u_pin (
        .clock_i        (CLOCK_I),
        .reset_i        (SYS_RST_I),
        .mode_i         ({flat_low[g], flat_high[g]}),
        .latch_i        (flat_latch[g]),
        .level_i        (level_sync[g]),
        .power_down_i   (POWER_DOWN_O),
        .pull_down_o    (PULL_DOWN_O[g]),
        .very_weak_up_o (VERY_WEAK_UP_O[g]),
        .weak_up_o      (WEAK_UP_O[g]),
        .strong_up_o    (STRONG_UP_O[g]),
        .input_enable_o (INPUT_ENABLE_O[g]),
        .level_o        (level_gated[g])
      );
    end
  endgenerate

  // Write decode check for the held address
  always @* begin
    next_wr_ok = 1'b1;
    case (aw_addr)
      `PORT0_MODE_SELECT_LOW_OFS, `PORT0_MODE_SELECT_HIGH_OFS,
      `PORT1_MODE_SELECT_LOW_OFS, `PORT1_MODE_SELECT_HIGH_OFS,
      `PORT2_MODE_SELECT_LOW_OFS, `PORT2_MODE_SELECT_HIGH_OFS,
      `PORT3_MODE_SELECT_LOW_OFS, `PORT3_MODE_SELECT_HIGH_OFS,
      `PORT0_LATCH_OFS, `PORT1_LATCH_OFS, `PORT2_LATCH_OFS, `PORT3_LATCH_OFS,
      `PORT0_LEVEL_OFS, `PORT1_LEVEL_OFS, `PORT2_LEVEL_OFS, `PORT3_LEVEL_OFS,
      `POWER_DOWN_OFS: next_wr_ok = 1'b1;
      default:         next_wr_ok = 1'b0;
    endcase
  end

  // Address and data accepted in either order, response after both
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `AXI_RESP_OKAY;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 8'h00;
      w_lane0         <= 1'b0;
      POWER_DOWN_O    <= `POWER_DOWN_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        mode_low[i]  <= `MODE_SELECT_RESET;
        mode_high[i] <= `MODE_SELECT_RESET;
        latch[i]     <= `LATCH_RESET;
      end
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_addr         <= S_AXI_AWADDR_I;
        aw_held         <= 1'b1;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_data         <= S_AXI_WDATA_I[7:0];
        w_lane0        <= S_AXI_WSTRB_I[0];
        w_held         <= 1'b1;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (aw_held && w_held && !S_AXI_BVALID_O) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= next_wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        // Only byte lane 0 carries register data
        if (w_lane0) begin
          case (aw_addr)
            `PORT0_MODE_SELECT_LOW_OFS:  mode_low[0]  <= w_data & `PORT0_MODE_MASK;
            `PORT0_MODE_SELECT_HIGH_OFS: mode_high[0] <= w_data & `PORT0_MODE_MASK;
            `PORT1_MODE_SELECT_LOW_OFS:  mode_low[1]  <= w_data;
            `PORT1_MODE_SELECT_HIGH_OFS: mode_high[1] <= w_data;
            `PORT2_MODE_SELECT_LOW_OFS:  mode_low[2]  <= w_data;
            `PORT2_MODE_SELECT_HIGH_OFS: mode_high[2] <= w_data;
            `PORT3_MODE_SELECT_LOW_OFS:  mode_low[3]  <= w_data;
            `PORT3_MODE_SELECT_HIGH_OFS: mode_high[3] <= w_data;
            `PORT0_LATCH_OFS:            latch[0]     <= w_data;
            `PORT1_LATCH_OFS:            latch[1]     <= w_data;
            `PORT2_LATCH_OFS:            latch[2]     <= w_data;
            `PORT3_LATCH_OFS:            latch[3]     <= w_data;
            `POWER_DOWN_OFS:             POWER_DOWN_O <= w_data[`POWER_DOWN_BIT];
            default:                     POWER_DOWN_O <= POWER_DOWN_O;
          endcase
        end
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  // Read mux; unmapped reads return zero with an error
  always @* begin
    next_rd_ok = 1'b1;
    next_rdata = 32'h00000000;
    case (S_AXI_ARADDR_I)
      `PORT0_MODE_SELECT_LOW_OFS:  next_rdata = {24'h000000, mode_low[0]};
      `PORT0_MODE_SELECT_HIGH_OFS: next_rdata = {24'h000000, mode_high[0]};
      `PORT1_MODE_SELECT_LOW_OFS:  next_rdata = {24'h000000, mode_low[1]};
      `PORT1_MODE_SELECT_HIGH_OFS: next_rdata = {24'h000000, mode_high[1]};
      `PORT2_MODE_SELECT_LOW_OFS:  next_rdata = {24'h000000, mode_low[2]};
      `PORT2_MODE_SELECT_HIGH_OFS: next_rdata = {24'h000000, mode_high[2]};
      `PORT3_MODE_SELECT_LOW_OFS:  next_rdata = {24'h000000, mode_low[3]};
      `PORT3_MODE_SELECT_HIGH_OFS: next_rdata = {24'h000000, mode_high[3]};
      `PORT0_LATCH_OFS:            next_rdata = {24'h000000, latch[0]};
      `PORT1_LATCH_OFS:            next_rdata = {24'h000000, latch[1]};
      `PORT2_LATCH_OFS:            next_rdata = {24'h000000, latch[2]};
      `PORT3_LATCH_OFS:            next_rdata = {24'h000000, latch[3]};
      `PORT0_LEVEL_OFS:            next_rdata = {28'h0000000, flat_level[3:0]};
      `PORT1_LEVEL_OFS:            next_rdata = {24'h000000, flat_level[11:4]};
      `PORT2_LEVEL_OFS:            next_rdata = {24'h000000, flat_level[19:12]};
      `PORT3_LEVEL_OFS:            next_rdata = {24'h000000, flat_level[27:20]};
      `POWER_DOWN_OFS:             next_rdata = {31'h00000000, POWER_DOWN_O};
      default:                     next_rd_ok = 1'b0;
    endcase
  end

  // One read at a time: address taken, data one cycle later
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h00000000;
      S_AXI_RRESP_O   <= `AXI_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RDATA_O   <= next_rdata;
        S_AXI_RRESP_O   <= next_rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O  <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

endmodule // port_pin_mode_config

// file: testbench/pin_mode_monitor.sv
// Port-level checker for the pin mode block
`timescale 1ns/100ps
module pin_mode_monitor #(
  parameter NUM_PINS = 27
) (
  input logic                CLOCK_I,
  input logic                SYS_RST_I,
  input logic                ARVALID_I,
  input logic                ARREADY_O,
  input logic                S_AXI_BVALID_O,
  input logic                S_AXI_BREADY_I,
  input logic [1:0]          S_AXI_BRESP_O,
  input logic                S_AXI_RVALID_O,
  input logic                S_AXI_RREADY_I,
  input logic [31:0]         S_AXI_RDATA_O,
  input logic [NUM_PINS-1:0] PIN_LEVEL_I,
  input logic [NUM_PINS-1:0] PULL_DOWN_O,
  input logic [NUM_PINS-1:0] VERY_WEAK_UP_O,
  input logic [NUM_PINS-1:0] WEAK_UP_O,
  input logic [NUM_PINS-1:0] STRONG_UP_O,
  input logic [NUM_PINS-1:0] INPUT_ENABLE_O,
  input logic                POWER_DOWN_O
);
  // Port 3 bits 2 and 3 keep their inputs alive in power-down
  localparam logic [26:0] WAKE_MASK = 27'hC00000;
  // Strong drive seen together with very weak means a quasi pin
  wire [NUM_PINS-1:0] quasi_strong = STRONG_UP_O & VERY_WEAK_UP_O;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_reset_state;
    $fell(SYS_RST_I) |-> (&VERY_WEAK_UP_O) && PULL_DOWN_O == 0 && STRONG_UP_O == 0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("pins not quasi after reset");
  property p_no_fight;
    (PULL_DOWN_O & (VERY_WEAK_UP_O | WEAK_UP_O | STRONG_UP_O)) == 0;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("pull-down and pull-up on together");
  property p_weak_needs_latch;
    (WEAK_UP_O & ~VERY_WEAK_UP_O) == 0;
  endproperty
  a_weak_needs_latch: assert property (p_weak_needs_latch)
    else $error("weak pull-up without latch one");
  property p_weak_off_low;
    (WEAK_UP_O & ~PIN_LEVEL_I & ~$past(PIN_LEVEL_I) & ~$past(PIN_LEVEL_I, 2)
     & ~$past(PIN_LEVEL_I, 3)) == 0;
  endproperty
  a_weak_off_low: assert property (p_weak_off_low)
    else $error("weak pull-up stays on a low pin");
  property p_pd_gate;
    POWER_DOWN_O && $past(POWER_DOWN_O) |-> (INPUT_ENABLE_O & ~WAKE_MASK) == 0;
  endproperty
  a_pd_gate: assert property (p_pd_gate)
    else $error("input left enabled in power-down");
  property p_wake_on;
    (INPUT_ENABLE_O & WAKE_MASK) == WAKE_MASK;
  endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("wake pin input disabled");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_answer;
    ARVALID_I && ARREADY_O |=> S_AXI_RVALID_O ##0 S_AXI_RDATA_O[31:8] == 0;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late or upper bits set");
  // Pulse length per pin; a wider window would hide a stuck strong drive
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    property p_strong_two;
      $rose(quasi_strong[i]) |=> quasi_strong[i] ##1 !quasi_strong[i];
    endproperty
    a_strong_two: assert property (p_strong_two)
      else $error("strong pull-up pulse not two clocks");
    property p_strong_cause;
      $rose(quasi_strong[i]) |-> $rose(VERY_WEAK_UP_O[i]);
    endproperty
    a_strong_cause: assert property (p_strong_cause)
      else $error("strong pull-up without latch rise");
  end
  c_pulse: cover property ($rose(|quasi_strong));
  c_power_down: cover property ($rose(POWER_DOWN_O));
  c_refused: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'b10);
endmodule // pin_mode_monitor

bind port_pin_mode_config pin_mode_monitor #(.NUM_PINS(NUM_PINS)) monitor (
  .ARVALID_I(S_AXI_ARVALID_I), .ARREADY_O(S_AXI_ARREADY_O), .*);

// file: testbench/pin_load_model.sv
// External pad load that resolves each pin level from the block's drives
`timescale 1ns/100ps
module pin_load_model (
  input  logic        clock_i,
  input  logic [26:0] pull_down_i,
  input  logic [26:0] pull_up_i,
  input  logic [26:0] ext_low_i,
  output logic [26:0] level_o
);
  initial level_o = 27'h0000000;
  // Low drive wins, an outside sink beats any pull-up, a floating pad wanders
  always @(posedge clock_i) begin
    level_o <= ~pull_down_i & ~ext_low_i & (pull_up_i | ~level_o);
  end
endmodule // pin_load_model

// file: testbench/port_pin_mode_config_bench.sv
// Self-checking bench for the pin mode block
`timescale 1ns/100ps
`include "port_cfg_regs.vh"
module port_pin_mode_config_bench;
  logic        clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, power_down;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  mode_lo [4], mode_hi [4], latch [4];
  logic [26:0] ext_low, level, pd, vw, wk, st, ie, e_pd, e_vw, e_wk, e_st;
  int          n_mismatch = 0, tests_run = 0;

  port_pin_mode_config DUT (.CLOCK_I(clock), .SYS_RST_I(sys_rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .PIN_LEVEL_I(level), .PULL_DOWN_O(pd), .VERY_WEAK_UP_O(vw),
    .WEAK_UP_O(wk), .STRONG_UP_O(st), .INPUT_ENABLE_O(ie), .POWER_DOWN_O(power_down));
  pin_load_model load (.clock_i(clock), .pull_down_i(pd), .pull_up_i(vw | wk | st),
    .ext_low_i(ext_low), .level_o(level));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      aw_done = aw_done | (awvalid & awready);
      w_done = w_done | (wvalid & wready);
      awvalid <= ~aw_done;
      wvalid <= ~w_done;
    end
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, {24'h000000, d}, r);
    chk("write response", `AXI_RESP_OKAY, r);
  endtask

  // Steady drive per pin from the mode pair and latch; flat index to port and bit
  function automatic void build_expect();
    int p, b;
    logic [1:0] m;
    for (int i = 0; i < 27; i++) begin
      p = (i < 4) ? 0 : (i - 4) / 8 + 1;
      b = (i < 4) ? i : (i - 4) % 8;
      m = {mode_lo[p][b], mode_hi[p][b]};
      e_pd[i] = (m != `MODE_INPUT_ONLY) && !latch[p][b];
      e_vw[i] = (m == `MODE_QUASI) && latch[p][b];
      e_wk[i] = e_vw[i] && !ext_low[i];
      e_st[i] = (m == `MODE_PUSH_PULL) && latch[p][b];
    end
  endfunction

  // Timeout well beyond the expected run of about 900 cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    int          seed;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h000000000000;
    ext_low = 27'h0000000;
    sys_rst = 1'b1;
    seed = $urandom(9435);
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      axi_read(8'(k * 4), d, r);
      chk("mode reset", 32'h00000000, d);
    end
    chk("very weak reset", 27'h7FFFFFF, vw);
    chk("input enable", 27'h7FFFFFF, ie);
    axi_write(8'h44, 32'hFFFFFFFF, r);
    chk("unmapped write", `AXI_RESP_SLVERR, r);
    axi_read(8'h44, d, r);
    chk("unmapped read", `AXI_RESP_SLVERR, r);
    chk("unmapped data", 32'h00000000, d);
    // Latches cleared before mode changes so every rise starts a fresh pulse
    for (int it = 0; it < 12; it++) begin
      for (int p = 0; p < 4; p++) begin
        latch[p] = 8'h00;
        wr(8'h20 + 8'(p * 4), 8'h00);
      end
      for (int k = 0; k < 8; k++) begin
        v = (it == 0) ? 8'hFF : 8'($urandom());
        wr(8'(k * 4), v);
        if (k < 2) v = v & `PORT0_MODE_MASK;
        if (k % 2 == 0) mode_lo[k / 2] = v;
        else mode_hi[k / 2] = v;
        axi_read(8'(k * 4), d, r);
        chk("mode readback", {24'h000000, v}, d);
      end
      ext_low <= 27'($urandom());
      for (int p = 0; p < 4; p++) begin
        latch[p] = 8'($urandom());
        wr(8'h20 + 8'(p * 4), latch[p]);
      end
      // Port 3 latches rose last, so its quasi pins are mid-pulse here
      @(posedge clock);
      build_expect();
      chk("strong pulse", e_st | (e_vw & 27'h7F00000), st);
      repeat (5) @(posedge clock);
      build_expect();
      chk("pull down", e_pd, pd);
      chk("very weak", e_vw, vw);
      chk("weak", e_wk, wk);
      chk("strong", e_st, st);
    end
    // Port 3 quasi and high, so its level register shows the gating
    ext_low <= 27'h0000000;
    wr(`PORT3_MODE_SELECT_LOW_OFS, 8'h00);
    wr(`PORT3_MODE_SELECT_HIGH_OFS, 8'h00);
    wr(`PORT3_LATCH_OFS, 8'hFF);
    wr(`POWER_DOWN_OFS, 8'h01);
    repeat (2) @(posedge clock);
    chk("power down", 32'h00000001, power_down);
    chk("input gate", 27'hC00000, ie);
    axi_read(`PORT3_LEVEL_OFS, d, r);
    chk("level gated", 32'h0000000C, d);
    wr(`POWER_DOWN_OFS, 8'h00);
    repeat (2) @(posedge clock);
    chk("input wake", 27'h7FFFFFF, ie);
    axi_read(`PORT3_LEVEL_OFS, d, r);
    chk("level awake", 32'h0000007F, d);
    stop_test();
  end
endmodule // port_pin_mode_config_bench
